// [src/bcc_defs.vh]
// constants for the bridge channel acquisition configuration block
`ifndef BCC_DEFS_VH
`define BCC_DEFS_VH
`define NUM_CH          48
`define CH_W            6
`define BLK_CH          16
// register offsets (byte addresses, one word each)
`define OFF_RATE        8'h00
`define OFF_SCAN_LO     8'h04
`define OFF_SCAN_HI     8'h08
`define OFF_CHSEL       8'h0C
`define OFF_CHCFG       8'h10
`define OFF_CORNER      8'h14
`define OFF_TARE        8'h18
`define OFF_SHUNT       8'h1C
`define OFF_TRIG        8'h20
`define OFF_CTRL        8'h24
`define OFF_INIT        8'h28
`define OFF_SCANCNT     8'h2C
`define OFF_ERR         8'h30
`define OFF_ORDER       8'h34
// rate table indices
`define IDX_RESET       5'h16
`define IDX_CONF        5'h13
`define IDX_3125        5'h1A
`define IDX_TOP         5'h1F
`define IDX_LAST        5'h1E
`define CENTI_W         22
// per-channel config word: [0] units [2:1] conv [4:3] iir type [8:5] order
// [9] transform [12:10] shunt mode
`define CFG_W           13
`define CFG_RESET       13'h0008
`define CORNER_RESET    32'h000003E8
`define TARE_RESET      32'h00000000
`define F_UNITS         0
`define F_CONV          2:1
`define F_IIR           4:3
`define F_ORDER         8:5
`define F_SHUNT         12:10
`define IIR_NONE        2'h0
`define IIR_BUTTER      2'h1
`define IIR_BESSEL      2'h2
`define ORDER_MAX       4'hA
`define CONV_STRAIN     2'h0
`define CONV_RATIO      2'h3
`define UNIT_MICRO      2'h1
`define UNIT_VOLT       2'h2
`define UNIT_NONE       2'h3
`define FC_MIN_MUL      10'h3E8
`define FC_MAX_MUL      2'h2
// shunt modes
`define SH_INT_REMOTE   3'h0
`define SH_INT_LOCAL    3'h1
`define SH_FP_REMOTE    3'h2
`define SH_FP_LOCAL     3'h3
`define SH_TEDS_REMOTE  3'h4
`define SH_CONN_BIT     8
// arm / trigger sources
`define SRC_IMMED       2'h0
`define SRC_TIMER       2'h1
`define SRC_DIO         2'h2
`define SRC_TBUS        2'h3
// one-hot sequencer states
`define ST_W            4
`define ST_IDLE         4'h1
`define ST_ARM          4'h2
`define ST_TRIG         4'h4
`define ST_ACQ          4'h8
// error bits: rate, scan list, channel config, shunt
`define ERR_W           4
// confidence system period: 2 ms at 25 ns clock
`define CONF_PERIOD_NS  2000000
`define CLK_PERIOD_NS   25
`define CONF_CYCLES     (`CONF_PERIOD_NS / `CLK_PERIOD_NS)
`define CONF_CNT_W      17
`endif

// [src/bcc_rate_round.v]
// sample rate table, nearest-rate rounding and index to rate lookup
`timescale 1ns/10ps
`include "bcc_defs.vh"
module bcc_rate_round (
  reqCenti,
  roundIdx,
  lookIdx,
  lookCenti
);
  input  wire [31:0]            reqCenti;
  output reg  [4:0]             roundIdx;
  input  wire [4:0]             lookIdx;
  output wire [`CENTI_W-1:0]    lookCenti;

  function [`CENTI_W-1:0] rateOf;
    input [4:0] i;
    begin
      case (i)
        5'h00: rateOf = 22'h000064;  5'h01: rateOf = 22'h0000C8;
        5'h02: rateOf = 22'h000190;  5'h03: rateOf = 22'h0001F4;
        5'h04: rateOf = 22'h000320;  5'h05: rateOf = 22'h0003E8;
        5'h06: rateOf = 22'h000640;  5'h07: rateOf = 22'h0007D0;
        5'h08: rateOf = 22'h0009C4;  5'h09: rateOf = 22'h000D05;
        5'h0A: rateOf = 22'h000FA0;  5'h0B: rateOf = 22'h001388;
        5'h0C: rateOf = 22'h001F40;  5'h0D: rateOf = 22'h002710;
        5'h0E: rateOf = 22'h0030D4;  5'h0F: rateOf = 22'h00411B;
        5'h10: rateOf = 22'h004E20;  5'h11: rateOf = 22'h0061A8;
        5'h12: rateOf = 22'h009C40;  5'h13: rateOf = 22'h00C350;
        5'h14: rateOf = 22'h00F424;  5'h15: rateOf = 22'h014585;
        5'h16: rateOf = 22'h0186A0;  5'h17: rateOf = 22'h01E848;
        5'h18: rateOf = 22'h030D40;  5'h19: rateOf = 22'h03D090;
        5'h1A: rateOf = 22'h04C4B4;  5'h1B: rateOf = 22'h07A120;
        5'h1C: rateOf = 22'h098968;  5'h1D: rateOf = 22'h0F4240;
        5'h1E: rateOf = 22'h1312D0;  default: rateOf = 22'h2625A0;
      endcase
    end
  endfunction

  assign lookCenti = rateOf(lookIdx);

  // above midpoint between neighbours i and i+1
  wire [30:0] aboveMid;
  genvar g;
  generate
    for (g = 0; g < 31; g = g + 1) begin : mid
      assign aboveMid[g] = {reqCenti, 1'b0} >
                           {9'h000, rateOf(g) + rateOf(g + 1)};
    end
  endgenerate

  integer k;
  always @* begin
    roundIdx = 5'h00;
    for (k = 0; k < 31; k = k + 1) begin
      roundIdx = roundIdx + {4'h0, aboveMid[k]};
    end
  end
endmodule

// [src/bcc_iir_order.v]
// automatic iir order from sample rate and corner (-200 dB at fs/2)
`timescale 1ns/10ps
`include "bcc_defs.vh"
module bcc_iir_order (
  fsCenti,
  fcCenti,
  autoOrder
);
  input  wire [`CENTI_W-1:0]  fsCenti;
  input  wire [31:0]          fcCenti;
  output reg  [3:0]           autoOrder;

  // 20 * 10^(10/n), rounded up, for n = 1..10
  function [39:0] thr;
    input [3:0] n;
    begin
      case (n)
        4'h1: thr = 40'h2E90EDD000;
        4'h2: thr = 40'h00001E8480;
        4'h3: thr = 40'h000000A851;
        4'h4: thr = 40'h00000018B5;
        4'h5: thr = 40'h00000007D0;
        4'h6: thr = 40'h00000003A1;
        4'h7: thr = 40'h0000000219;
        4'h8: thr = 40'h0000000164;
        4'h9: thr = 40'h0000000103;
        default: thr = 40'h00000000C8;
      endcase
    end
  endfunction

  wire [25:0] fsTen = fsCenti * 4'hA;
  wire [9:0]  enough;
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : ord
      assign enough[g] = {46'h0, fsTen} >= fcCenti * thr(g + 1);
    end
  endgenerate

  integer k;
  reg [3:0] cnt;
  always @* begin
    cnt = 4'h0;
    for (k = 0; k < 10; k = k + 1) begin
      cnt = cnt + {3'h0, enough[k]};
    end
    autoOrder = (cnt == 4'h0) ? `ORDER_MAX : `ORDER_MAX + 4'h1 - cnt;
  end
endmodule

// [src/bcc_channel_config.v]
// per-channel acquisition configuration, trigger sequencer and shunt switches
// Contract
// - only discrete rates from 1 to 12500 Sa/s, any scan list size
// - 25000 Sa/s only with active channels inside one 16-channel group
// - in-between requests round to the nearest permitted rate
// - confidence results every 2 ms; above 500 Sa/s some scans lack them
// - rate is 1000 Sa/s after reset
// - per-channel strain/microstrain unit; volts and unitless for others
// - tare never rescaled when unit or conversion changes
// - per-channel tare, default 0, subtracted from main data only
// - fixed FIR chosen by rate alone, looser ripple from 3125 Sa/s up
// - per-channel iir type and corner from fs/1000 to a rate maximum
// - order 0..10 for Butterworth, 1..10 for Bessel, else invalid
// - order 0 means computed order, -200 dB at fs/2
// - default Butterworth, 10 Hz, bilinear, order 0 giving 6
// - initialize, then arm event, then trigger event, then acquire
// - arm and trigger sources chosen independently among four
// - scans carry readings and start time; confidence only if enabled
// - internal shunt via switch C local or B remote, all channels
// - front panel shunt: D,F local or A,F remote, one per block
// - smart-sensor shunt closes A and E, one per block
// - shunt mode and connect state are separate; mode never connects
// - reset gives internal remote mode and all shunts open
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/10ps
`include "bcc_defs.vh"
module bcc_channel_config #(
  parameter CONF_CYCLES = `CONF_CYCLES
) (
  ref_clk,
  rstn,
  regAddr,
  regWrData,
  regWr,
  regRd,
  regRdData,
  sampleTick,
  timerTick,
  dioEvent,
  trigBusEvent,
  rawValid,
  rawChan,
  rawData,
  rawIsConf,
  acqActive,
  scanStart,
  scanTime,
  scanHasConf,
  outValid,
  outChan,
  outData,
  outIsConf,
  outUnitCode,
  firSel,
  firTightRipple,
  swA,
  swB,
  swC,
  swD,
  swE,
  swF
);
  input  wire                 ref_clk;
  input  wire                 rstn;
  input  wire [7:0]           regAddr;
  input  wire [31:0]          regWrData;
  input  wire                 regWr;
  input  wire                 regRd;
  output reg  [31:0]          regRdData;
  input  wire                 sampleTick;
  input  wire                 timerTick;
  input  wire                 dioEvent;
  input  wire                 trigBusEvent;
  input  wire                 rawValid;
  input  wire [`CH_W-1:0]     rawChan;
  input  wire [31:0]          rawData;
  input  wire                 rawIsConf;
  output reg                  acqActive;
  output reg                  scanStart;
  output reg  [31:0]          scanTime;
  output reg                  scanHasConf;
  output reg                  outValid;
  output reg  [`CH_W-1:0]     outChan;
  output reg  [31:0]          outData;
  output reg                  outIsConf;
  output reg  [1:0]           outUnitCode;
  output reg  [4:0]           firSel;
  output reg                  firTightRipple;
  output reg  [`NUM_CH-1:0]   swA;
  output reg  [`NUM_CH-1:0]   swB;
  output reg  [`NUM_CH-1:0]   swC;
  output reg  [`NUM_CH-1:0]   swD;
  output reg  [`NUM_CH-1:0]   swE;
  output reg  [`NUM_CH-1:0]   swF;

  reg  [4:0]                  rateIdx_reg;
  reg  [`NUM_CH-1:0]          scanMask_reg;
  reg  [15:0]                 scanLoStage_reg;
  reg  [`CH_W-1:0]            chSel_reg;
  reg  [3:0]                  trigSel_reg;
  reg  [1:0]                  ctrl_reg;
  reg  [31:0]                 scanCnt_reg;
  reg  [31:0]                 scanDone_reg;
  reg  [`ERR_W-1:0]           err_reg;
  reg  [`ST_W-1:0]            state_reg;
  reg  [`ST_W-1:0]            state_next;
  reg  [`CONF_CNT_W-1:0]      confCnt_reg;
  reg                         confFresh_reg;
  reg  [31:0]                 timeCnt_reg;
  wire [4:0]                  reqIdx;
  wire [`CENTI_W-1:0]         fsCenti;
  wire [3:0]                  autoOrder;
  wire [`NUM_CH*`CFG_W-1:0]   cfgFlat;
  wire [`NUM_CH*32-1:0]       cornerFlat;
  wire [`NUM_CH*32-1:0]       tareFlat;
  wire [`NUM_CH-1:0]          conn;
  wire [`NUM_CH-1:0]          excl;
  wire [`NUM_CH-1:0]          swANext;
  wire [`NUM_CH-1:0]          swBNext;
  wire [`NUM_CH-1:0]          swCNext;
  wire [`NUM_CH-1:0]          swDNext;
  wire [`NUM_CH-1:0]          swENext;
  wire [`NUM_CH-1:0]          swFNext;

  function groupOk;
    input [`NUM_CH-1:0] m;
    begin
      groupOk = (|m) && ((m[47:16] == 32'h0) ||
                ((m[47:32] == 16'h0) && (m[15:0] == 16'h0)) ||
                (m[31:0] == 32'h0));
    end
  endfunction

  function isExcl;
    input [2:0] mode;
    begin
      isExcl = (mode == `SH_FP_REMOTE) || (mode == `SH_FP_LOCAL) ||
               (mode == `SH_TEDS_REMOTE);
    end
  endfunction

  // another channel of ch's block already holds an exclusive shunt
  function blkBusy;
    input [`NUM_CH-1:0] ex;
    input [`CH_W-1:0]   ch;
    reg   [`NUM_CH-1:0] t;
    begin
      t = ex;
      t[ch] = 1'b0;
      blkBusy = |t[ch[5:4]*`BLK_CH +: `BLK_CH];
    end
  endfunction

  bcc_rate_round uRate (
    .reqCenti  (regWrData),
    .roundIdx  (reqIdx),
    .lookIdx   (rateIdx_reg),
    .lookCenti (fsCenti)
  );

  wire [31:0] selCorner = cornerFlat[chSel_reg*32 +: 32];

  bcc_iir_order uOrder (
    .fsCenti   (fsCenti),
    .fcCenti   (selCorner),
    .autoOrder (autoOrder)
  );

  wire wrRate   = regWr && (regAddr == `OFF_RATE);
  wire wrScanLo = regWr && (regAddr == `OFF_SCAN_LO);
  wire wrScanHi = regWr && (regAddr == `OFF_SCAN_HI);
  wire wrChSel  = regWr && (regAddr == `OFF_CHSEL);
  wire wrCfg    = regWr && (regAddr == `OFF_CHCFG);
  wire wrCorner = regWr && (regAddr == `OFF_CORNER);
  wire wrTare   = regWr && (regAddr == `OFF_TARE);
  wire wrShunt  = regWr && (regAddr == `OFF_SHUNT);
  wire wrTrig   = regWr && (regAddr == `OFF_TRIG);
  wire wrCtrl   = regWr && (regAddr == `OFF_CTRL);
  wire wrInit   = regWr && (regAddr == `OFF_INIT);
  wire wrCnt    = regWr && (regAddr == `OFF_SCANCNT);
  wire wrErr    = regWr && (regAddr == `OFF_ERR);

  wire selValid = chSel_reg < `NUM_CH;
  // rounding may land on the top rate, which needs the group check
  wire rateOk = !((reqIdx == `IDX_TOP) && !groupOk(scanMask_reg));
  wire [`NUM_CH-1:0] newMask = {regWrData[31:0], scanLoStage_reg};
  wire scanOk = (|newMask) &&
                !((rateIdx_reg == `IDX_TOP) && !groupOk(newMask));
  wire [`CFG_W-1:0] wCfg = regWrData[`CFG_W-1:0];
  wire orderOk = (wCfg[`F_IIR] == `IIR_NONE) ||
                 ((wCfg[`F_IIR] == `IIR_BUTTER) && (wCfg[`F_ORDER] <= `ORDER_MAX)) ||
                 ((wCfg[`F_IIR] == `IIR_BESSEL) && (wCfg[`F_ORDER] != 4'h0) &&
                  (wCfg[`F_ORDER] <= `ORDER_MAX));
  wire modeOk = (wCfg[`F_SHUNT] <= `SH_TEDS_REMOTE) &&
                !(conn[chSel_reg] && isExcl(wCfg[`F_SHUNT]) &&
                  blkBusy(excl, chSel_reg));
  wire cfgOk = selValid && orderOk && modeOk;
  wire [41:0] cornerLo = regWrData * `FC_MIN_MUL;
  wire [33:0] cornerHi = regWrData * `FC_MAX_MUL;
  wire cornerOk = selValid && (cornerLo >= {20'h0, fsCenti}) &&
                  (cornerHi <= {12'h0, fsCenti});
  wire [`CH_W-1:0] shCh = regWrData[`CH_W-1:0];
  wire shConn = regWrData[`SH_CONN_BIT];
  wire shChOk = shCh < `NUM_CH;
  wire [2:0] shMode = cfgFlat[shCh*`CFG_W + 10 +: 3];
  wire shuntOk = shChOk &&
                 !(shConn && isExcl(shMode) && blkBusy(excl, shCh));

  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g = g + 1) begin : ch
      reg [`CFG_W-1:0] cfg_reg;
      reg [31:0]       corner_reg;
      reg [31:0]       tare_reg;
      reg              conn_reg;
      wire [2:0]       mode = cfg_reg[`F_SHUNT];
      always @(posedge ref_clk) begin
        if (!rstn) begin
          cfg_reg    <= `CFG_RESET;
          corner_reg <= `CORNER_RESET;
          tare_reg   <= `TARE_RESET;
          conn_reg   <= 1'b0;
        end else begin
          // mode and units change without touching connection or tare
          if (wrCfg && cfgOk && (chSel_reg == g)) cfg_reg <= wCfg;
          if (wrCorner && cornerOk && (chSel_reg == g)) corner_reg <= regWrData;
          if (wrTare && selValid && (chSel_reg == g)) tare_reg <= regWrData;
          if (wrShunt && shuntOk && (shCh == g)) conn_reg <= shConn;
        end
      end
      assign cfgFlat[g*`CFG_W +: `CFG_W] = cfg_reg;
      assign cornerFlat[g*32 +: 32] = corner_reg;
      assign tareFlat[g*32 +: 32] = tare_reg;
      assign conn[g] = conn_reg;
      assign excl[g] = conn_reg && isExcl(mode);
      assign swANext[g] = conn_reg && ((mode == `SH_FP_REMOTE) ||
                                       (mode == `SH_TEDS_REMOTE));
      assign swBNext[g] = conn_reg && (mode == `SH_INT_REMOTE);
      assign swCNext[g] = conn_reg && (mode == `SH_INT_LOCAL);
      assign swDNext[g] = conn_reg && (mode == `SH_FP_LOCAL);
      assign swENext[g] = conn_reg && (mode == `SH_TEDS_REMOTE);
      assign swFNext[g] = conn_reg && ((mode == `SH_FP_REMOTE) ||
                                       (mode == `SH_FP_LOCAL));
    end
  endgenerate

  // sequencer event selection
  function srcHit;
    input [1:0] src;
    begin
      case (src)
        `SRC_IMMED: srcHit = 1'b1;
        `SRC_TIMER: srcHit = timerTick;
        `SRC_DIO:   srcHit = dioEvent;
        default:    srcHit = trigBusEvent;
      endcase
    end
  endfunction

  wire abortCmd = wrInit && regWrData[1];
  wire lastScan = (scanCnt_reg != 32'h0) && (scanDone_reg == scanCnt_reg);
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ST_IDLE: if (wrInit && regWrData[0]) state_next = `ST_ARM;
      `ST_ARM:  if (srcHit(trigSel_reg[1:0])) state_next = `ST_TRIG;
      `ST_TRIG: if (srcHit(trigSel_reg[3:2])) state_next = `ST_ACQ;
      `ST_ACQ:  if (sampleTick && lastScan) state_next = `ST_IDLE;
      default:  state_next = `ST_IDLE;
    endcase
    if (abortCmd) state_next = `ST_IDLE;
  end

  wire inAcq = (state_reg == `ST_ACQ);
  wire newScan = inAcq && sampleTick && !lastScan;
  wire confTick = ctrl_reg[0] && (confCnt_reg == CONF_CYCLES - 1);
  wire [`ERR_W-1:0] errSet = {wrShunt && !shuntOk,
                              (wrCfg && !cfgOk) || (wrCorner && !cornerOk),
                              wrScanHi && !scanOk,
                              wrRate && !rateOk};
  wire [`ERR_W-1:0] errClr = wrErr ? regWrData[`ERR_W-1:0] : {`ERR_W{1'b0}};
  wire [1:0] rawConv = cfgFlat[rawChan*`CFG_W + 1 +: 2];
  wire rawMicro = cfgFlat[rawChan*`CFG_W];

  always @(posedge ref_clk) begin
    if (!rstn) begin
      rateIdx_reg     <= `IDX_RESET;
      scanMask_reg    <= {`NUM_CH{1'b1}};
      scanLoStage_reg <= 16'h0000;
      chSel_reg       <= {`CH_W{1'b0}};
      trigSel_reg     <= 4'h0;
      ctrl_reg        <= 2'h0;
      scanCnt_reg     <= 32'h00000000;
      scanDone_reg    <= 32'h00000000;
      err_reg         <= {`ERR_W{1'b0}};
      state_reg       <= `ST_IDLE;
      confCnt_reg     <= {`CONF_CNT_W{1'b0}};
      confFresh_reg   <= 1'b0;
      timeCnt_reg     <= 32'h00000000;
    end else begin
      if (wrRate && rateOk) rateIdx_reg <= reqIdx;
      if (wrScanLo) scanLoStage_reg <= regWrData[15:0];
      if (wrScanHi && scanOk) scanMask_reg <= newMask;
      if (wrChSel) chSel_reg <= regWrData[`CH_W-1:0];
      if (wrTrig) trigSel_reg <= regWrData[3:0];
      if (wrCtrl) ctrl_reg <= regWrData[1:0];
      if (wrCnt) scanCnt_reg <= regWrData;
      err_reg <= (err_reg & ~errClr) | errSet;
      state_reg <= state_next;
      if (state_reg == `ST_TRIG) scanDone_reg <= 32'h00000000;
      else if (newScan) scanDone_reg <= scanDone_reg + 32'h00000001;
      confCnt_reg <= (!ctrl_reg[0] || confTick) ? {`CONF_CNT_W{1'b0}} :
                     confCnt_reg + {{(`CONF_CNT_W-1){1'b0}}, 1'b1};
      // a result arriving with a scan start stays fresh for the next scan
      if (confTick) confFresh_reg <= 1'b1;
      else if (newScan) confFresh_reg <= 1'b0;
      timeCnt_reg <= timeCnt_reg + 32'h00000001;
    end
  end

  // registered outputs
  always @(posedge ref_clk) begin
    if (!rstn) begin
      regRdData      <= 32'h00000000;
      acqActive      <= 1'b0;
      scanStart      <= 1'b0;
      scanTime       <= 32'h00000000;
      scanHasConf    <= 1'b0;
      outValid       <= 1'b0;
      outChan        <= {`CH_W{1'b0}};
      outData        <= 32'h00000000;
      outIsConf      <= 1'b0;
      outUnitCode    <= 2'h0;
      firSel         <= `IDX_RESET;
      firTightRipple <= 1'b1;
      swA <= {`NUM_CH{1'b0}};
      swB <= {`NUM_CH{1'b0}};
      swC <= {`NUM_CH{1'b0}};
      swD <= {`NUM_CH{1'b0}};
      swE <= {`NUM_CH{1'b0}};
      swF <= {`NUM_CH{1'b0}};
    end else begin
      acqActive <= inAcq;
      scanStart <= newScan;
      if (newScan) begin
        scanTime    <= timeCnt_reg;
        scanHasConf <= ctrl_reg[0] && ctrl_reg[1] &&
                       ((rateIdx_reg <= `IDX_CONF) || confFresh_reg);
      end
      outValid  <= inAcq && rawValid && (rawChan < `NUM_CH) &&
                   (!rawIsConf || (ctrl_reg[0] && ctrl_reg[1]));
      outChan   <= rawChan;
      outIsConf <= rawIsConf;
      outData   <= rawIsConf ? rawData :
                   rawData - tareFlat[rawChan*32 +: 32];
      if (rawConv == `CONV_STRAIN)
        outUnitCode <= rawMicro ? `UNIT_MICRO : `CONV_STRAIN;
      else
        outUnitCode <= (rawConv == `CONV_RATIO) ? `UNIT_NONE : `UNIT_VOLT;
      firSel         <= rateIdx_reg;
      firTightRipple <= rateIdx_reg < `IDX_3125;
      swA <= swANext;
      swB <= swBNext;
      swC <= swCNext;
      swD <= swDNext;
      swE <= swENext;
      swF <= swFNext;
      regRdData <= 32'h00000000;
      if (regRd) begin
        case (regAddr)
          `OFF_RATE:    regRdData <= {3'h0, rateIdx_reg, 2'h0, fsCenti};
          `OFF_SCAN_LO: regRdData <= scanMask_reg[31:0];
          `OFF_SCAN_HI: regRdData <= {16'h0000, scanMask_reg[47:32]};
          `OFF_CHSEL:   regRdData <= {26'h0, chSel_reg};
          `OFF_CHCFG:   regRdData <= {19'h0, cfgFlat[chSel_reg*`CFG_W +: `CFG_W]};
          `OFF_CORNER:  regRdData <= selCorner;
          `OFF_TARE:    regRdData <= tareFlat[chSel_reg*32 +: 32];
          `OFF_SHUNT:   regRdData <= {23'h0, conn[chSel_reg], 8'h00};
          `OFF_TRIG:    regRdData <= {28'h0, trigSel_reg};
          `OFF_CTRL:    regRdData <= {30'h0, ctrl_reg};
          `OFF_INIT:    regRdData <= {28'h0, state_reg};
          `OFF_SCANCNT: regRdData <= scanCnt_reg;
          `OFF_ERR:     regRdData <= {28'h0, err_reg};
          `OFF_ORDER:   regRdData <= {28'h0,
                          (cfgFlat[chSel_reg*`CFG_W + 5 +: 4] == 4'h0) ?
                          autoOrder : cfgFlat[chSel_reg*`CFG_W + 5 +: 4]};
          default:      regRdData <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// [tb/bcc_chk_sva.sv]
// assertions on the channel configuration block ports
`timescale 1ns/10ps
`include "bcc_defs.vh"
module bcc_chk_sva (
  input wire               ref_clk, rstn, sampleTick, rawValid, rawIsConf, acqActive,
  input wire               scanStart, outValid, outIsConf, firTightRipple,
  input wire [`CH_W-1:0]   rawChan, outChan,
  input wire [4:0]         firSel,
  input wire [`NUM_CH-1:0] swA, swB, swC, swD, swE, swF
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_main;
    rawValid && !rawIsConf && rawChan < 6'h30;
  endsequence
  // acqActive one cycle later mirrors the acquire state at the sample edge
  property p_echo; s_main ##1 acqActive |->
    outValid && !outIsConf && outChan == $past(rawChan); endproperty
  property p_rst; $rose(rstn) |-> firSel == 5'h16; endproperty
  property p_fir; firTightRipple == (firSel < 5'h1A); endproperty
  property p_bc; (swB & swC) == 48'h0; endproperty
  property p_df; (swD & ~swF) == 48'h0; endproperty
  property p_blk; $onehot0(swF[15:0]) && $onehot0(swF[31:16]) && $onehot0(swF[47:32]); endproperty
  property p_te; $onehot0(swE[15:0]) && $onehot0(swE[31:16]) && $onehot0(swE[47:32]); endproperty
  property p_ae; (swA & ~(swE | swF)) == 48'h0; endproperty
  property p_scan; scanStart |-> $past(sampleTick); endproperty
  a_echo: assert property (p_echo) else $error("main result not echoed");
  a_rst: assert property (p_rst) else $error("rate index wrong after reset");
  a_fir: assert property (p_fir) else $error("ripple select wrong");
  a_bc: assert property (p_bc) else $error("switch B and C together");
  a_df: assert property (p_df) else $error("switch D without F");
  a_blk: assert property (p_blk) else $error("two panel shunts in a block");
  a_te: assert property (p_te) else $error("two sensor shunts in a block");
  a_ae: assert property (p_ae) else $error("switch A without E or F");
  a_scan: assert property (p_scan) else $error("scan start without tick");
endmodule
bind bcc_channel_config bcc_chk_sva u_chk (.ref_clk, .rstn, .sampleTick, .rawValid,
  .rawIsConf, .acqActive, .scanStart, .outValid, .outIsConf, .firTightRipple, .rawChan,
  .outChan, .firSel, .swA, .swB, .swC, .swD, .swE, .swF);

// [tb/bcc_adc_model.sv]
// sample tick and timer event source in front of the block
`timescale 1ns/10ps
module bcc_adc_model (
  input  wire ref_clk,
  input  wire rstn,
  output reg  sampleTick,
  output reg  timerTick
);
  reg [4:0] tickCnt_reg;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      tickCnt_reg <= 5'h00;
    end else begin
      tickCnt_reg <= tickCnt_reg + 5'h01;
    end
    sampleTick <= rstn && (tickCnt_reg[2:0] == 3'h7);
    timerTick <= rstn && (tickCnt_reg == 5'h1F);
  end
endmodule

// [tb/bcc_channel_config_tb.sv]
// self-checking bench for the channel configuration block
`timescale 1ns/10ps
`include "bcc_defs.vh"
module bcc_channel_config_tb;
  reg         ref_clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, rdPend = 1'b0;
  reg         rawValid = 1'b0, rawIsConf = 1'b0;
  reg  [7:0]  regAddr = 8'h00;
  reg  [5:0]  rawChan = 6'h00;
  reg  [31:0] regWrData = 32'h0, rawData = 32'h0, seed = 32'h00017CE4;
  wire [31:0] regRdData, scanTime, outData;
  wire        sampleTick, timerTick, acqActive, scanStart, scanHasConf, outValid, outIsConf;
  wire        firTightRipple;
  wire [5:0]  outChan;
  wire [1:0]  outUnitCode;
  wire [4:0]  firSel;
  wire [47:0] swA, swB, swC, swD, swE, swF;
  integer     failures = 0, comparisons = 0, cycles = 0, k;
  reg  [40:0] rdQ[$], outQ[$];
  reg         scanSeen = 1'b0;
  reg  [31:0] prevTime = 32'h0;
  always #12.5 ref_clk = ~ref_clk;
  bcc_channel_config #(.CONF_CYCLES(20)) dut_u (.ref_clk, .rstn, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .sampleTick, .timerTick, .dioEvent(1'b0),
    .trigBusEvent(1'b0), .rawValid, .rawChan, .rawData, .rawIsConf, .acqActive, .scanStart,
    .scanTime, .scanHasConf, .outValid, .outChan, .outData, .outIsConf, .outUnitCode,
    .firSel, .firTightRipple, .swA, .swB, .swC, .swD, .swE, .swF);
  bcc_adc_model model_u (.ref_clk, .rstn, .sampleTick, .timerTick);
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input [40:0] seen, input [40:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    regRd <= 1'b1;
    regAddr <= a;
    rdQ.push_back({9'h000, e});
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task raw(input [5:0] c, input conf, input [31:0] tare, input [1:0] u);
    seed = lfsr(seed);
    rawValid <= 1'b1;
    rawChan <= c;
    rawIsConf <= conf;
    rawData <= seed;
    outQ.push_back({conf, u, c, seed - tare});
    @(posedge ref_clk);
    rawValid <= 1'b0;
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (rdPend) check({9'h000, regRdData}, rdQ.pop_front());
    rdPend <= regRd;
    if (outValid) check({outIsConf, outIsConf ? 2'h0 : outUnitCode, outChan, outData}, outQ.pop_front());
    if (scanStart) begin
      if (scanSeen) check(scanTime - prevTime, 32'h8);
      scanSeen = 1'b1;
      prevTime = scanTime;
    end
    if (cycles > 3000) begin
      failures = failures + 1;
      complete_run;
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(8'h00, 32'h160186A0);
    rd(8'h34, 32'h00000006);
    wr(8'h00, 32'h002625A0);
    rd(8'h00, 32'h160186A0);
    wr(8'h04, 32'h0000FFFF);
    wr(8'h08, 32'h00000000);
    wr(8'h00, 32'h002625A0);
    rd(8'h00, 32'h1F2625A0);
    wr(8'h00, 32'h00001004);
    rd(8'h00, 32'h0A000FA0);
    check({firTightRipple, firSel}, 6'h2A);
    wr(8'h10, 32'h00000C08);
    repeat (2) @(posedge ref_clk);
    check(swD[0], 1'b0);
    wr(8'h1C, 32'h00000100);
    wr(8'h0C, 32'h00000001);
    wr(8'h10, 32'h00000C08);
    wr(8'h1C, 32'h00000101);
    wr(8'h0C, 32'h00000010);
    wr(8'h10, 32'h00001008);
    wr(8'h1C, 32'h00000110);
    rd(8'h30, 32'h00000009);
    check({swD[1:0], swF[1:0], swB[0]}, 5'h0A);
    check({swA[16], swE[16], swF[16], swB[16]}, 4'hC);
    wr(8'h0C, 32'h00000005);
    wr(8'h18, 32'h00000007);
    wr(8'h10, 32'h00000009);
    wr(8'h0C, 32'h00000002);
    wr(8'h18, 32'h00000005);
    wr(8'h24, 32'h00000003);
    wr(8'h20, 32'h00000004);
    check(acqActive, 1'b0);
    wr(8'h28, 32'h00000001);
    for (k = 0; k < 200 && acqActive !== 1'b1; k = k + 1) @(posedge ref_clk);
    raw(6'h02, 1'b0, 32'h5, 2'h0);
    raw(6'h02, 1'b1, 32'h0, 2'h0);
    raw(6'h05, 1'b0, 32'h7, 2'h1);
    repeat (20) @(posedge ref_clk);
    check(scanHasConf, 1'b1);
    check(scanSeen, 1'b1);
    check(outQ.size() + rdQ.size(), 0);
    complete_run;
  end
endmodule
